// >>> ecdp_channel.sv
// ecdp_channel.sv: one 8-bit channel: event counter, divider output, pwm.
// assumes synchronous inputs, a plain register port and one clock mclk.
//
// Behaviour
// - event mode counts each falling input edge
// - event match raises irq, clears, keeps counting
// - match register unbuffered in event, divider modes
// - divider match toggles, clears, raises irq together
// - divider gives half period of match ticks
// - divider pin is inverse flop; preset; reset clears
// - divider stop holds pin; preset written afterwards
// - run bit stops; preset zero drives pin high
// - pwm toggles on duty match and overflow
// - pwm irq at overflow and clear
// - pwm pin is inverse flop; preset; reset clears
// - duty double buffered; stopped writes load immediately
// - duty read returns active value until irq
// - pwm stop holds pin; preset written afterwards
`timescale 1ns/10ps
`include "ecdp_map.svh"

module ecdp_channel (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire ecdp_pkg::ecdp_bus_req_t bus_req,
   output logic [7:0] rd_data,
   // source inputs
   input wire logic event_input_pin,
   input wire logic low_speed_osc,
   // outputs
   output logic divider_out_pin,
   output logic pwm_out_pin,
   output logic channel_match_irq
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   ecdp_pkg::ecdp_ctrl_t ctrl_r, ctrl_nxt;
   logic [7:0] match_value_reg_r, match_value_reg_nxt;
   logic [7:0] duty_stage_r, duty_stage_nxt;
   logic [7:0] duty_compare_reg_r, duty_compare_reg_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic ff_r, ff_nxt;
   logic ev_prev_r, ev_prev_nxt;
   logic irq_r, irq_nxt;
   logic div_pin_r, div_pin_nxt;
   logic pwm_pin_r, pwm_pin_nxt;
   logic [7:0] rd_r, rd_nxt;

   logic src_tick;
   logic fall;
   logic [7:0] inc;
   ecdp_pkg::ecdp_ctrl_t wr_ctrl;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] ecdp_bump(input logic [7:0] v);
      ecdp_bump = v + 8'h01;
   endfunction

   function automatic logic ecdp_hit(input logic [7:0] v, input logic [7:0] ref_v);
      ecdp_hit = (ecdp_bump(v) == ref_v);
   endfunction

   // ----------------------------------------------------------------------
   // source clock
   // ----------------------------------------------------------------------
   ecdp_prescaler u_pre (
      .mclk(mclk),
      .rst(rst),
      .src(ctrl_r.src),
      .pre_src(ctrl_r.pre_src),
      .low_speed_osc(low_speed_osc),
      .tick(src_tick)
   );

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      match_value_reg_nxt = match_value_reg_r;
      duty_stage_nxt = duty_stage_r;
      duty_compare_reg_nxt = duty_compare_reg_r;
      cnt_nxt = cnt_r;
      ff_nxt = ff_r;
      irq_nxt = 1'b0;
      ev_prev_nxt = event_input_pin;
      rd_nxt = 8'h00;
      wr_ctrl = ecdp_pkg::ecdp_ctrl_t'(bus_req.wdata);
      // input assumed to hold each phase two cycles or more
      fall = ev_prev_r & ~event_input_pin;
      inc = ecdp_bump(cnt_r);

      // register writes
      if (bus_req.wr) begin
         if (bus_req.addr == `ECDP_OFF_CTRL) begin
            ctrl_nxt = wr_ctrl;
            // preset only while stopped; the stopping write leaves the flop
            if (!ctrl_r.run) begin
               ff_nxt = wr_ctrl.preset;
            end
         end else if (bus_req.addr == `ECDP_OFF_MATCH) begin
            match_value_reg_nxt = bus_req.wdata;
         end else if (bus_req.addr == `ECDP_OFF_DUTY) begin
            duty_stage_nxt = bus_req.wdata;
            if (!ctrl_r.run) begin
               duty_compare_reg_nxt = bus_req.wdata;
            end
         end
      end

      // counting
      if (ctrl_r.run) begin
         case (ctrl_r.mode)
            ecdp_pkg::ECDP_MODE_EVT: begin
               if (fall) begin
                  if (ecdp_hit(cnt_r, match_value_reg_r)) begin
                     cnt_nxt = 8'h00;
                     irq_nxt = 1'b1;
                  end else begin
                     cnt_nxt = inc;
                  end
               end
            end
            ecdp_pkg::ECDP_MODE_DIV: begin
               if (src_tick) begin
                  if (ecdp_hit(cnt_r, match_value_reg_r)) begin
                     cnt_nxt = 8'h00;
                     ff_nxt = ~ff_r;
                     irq_nxt = 1'b1;
                  end else begin
                     cnt_nxt = inc;
                  end
               end
            end
            ecdp_pkg::ECDP_MODE_PWM: begin
               if (src_tick) begin
                  if (cnt_r == `ECDP_CNT_TOP) begin
                     cnt_nxt = 8'h00;
                     ff_nxt = ~ff_r;
                     irq_nxt = 1'b1;
                     // a write in this cycle is the one transferred
                     duty_compare_reg_nxt = duty_stage_nxt;
                  end else begin
                     cnt_nxt = inc;
                     if (inc == duty_compare_reg_r) begin
                        ff_nxt = ~ff_r;
                     end
                  end
               end
            end
            default: begin
               cnt_nxt = cnt_r;
            end
         endcase
      end else begin
         // stopped: counter cleared, flop and pins hold
         cnt_nxt = 8'h00;
      end

      // pins follow the inverse flop in every mode
      div_pin_nxt = ~ff_nxt;
      pwm_pin_nxt = ~ff_nxt;

      // register reads
      if (bus_req.rd) begin
         if (bus_req.addr == `ECDP_OFF_CTRL) begin
            rd_nxt = ctrl_r;
         end else if (bus_req.addr == `ECDP_OFF_MATCH) begin
            rd_nxt = match_value_reg_r;
         end else if (bus_req.addr == `ECDP_OFF_DUTY) begin
            rd_nxt = duty_compare_reg_r;
         end else begin
            rd_nxt = cnt_r;
         end
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_r <= ecdp_pkg::ecdp_ctrl_t'(`ECDP_RST_CTRL);
         match_value_reg_r <= `ECDP_RST_MATCH;
         duty_stage_r <= `ECDP_RST_DUTY;
         duty_compare_reg_r <= `ECDP_RST_DUTY;
         cnt_r <= 8'h00;
         ff_r <= 1'b0;
         ev_prev_r <= 1'b1;
         irq_r <= 1'b0;
         div_pin_r <= 1'b1;
         pwm_pin_r <= 1'b1;
         rd_r <= 8'h00;
      end else begin
         ctrl_r <= ctrl_nxt;
         match_value_reg_r <= match_value_reg_nxt;
         duty_stage_r <= duty_stage_nxt;
         duty_compare_reg_r <= duty_compare_reg_nxt;
         cnt_r <= cnt_nxt;
         ff_r <= ff_nxt;
         ev_prev_r <= ev_prev_nxt;
         irq_r <= irq_nxt;
         div_pin_r <= div_pin_nxt;
         pwm_pin_r <= pwm_pin_nxt;
         rd_r <= rd_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign rd_data = rd_r;
   assign divider_out_pin = div_pin_r;
   assign pwm_out_pin = pwm_pin_r;
   assign channel_match_irq = irq_r;

endmodule

// >>> ecdp_channel_chk_sva.sv
// port assertions for one counter/divider/pwm channel
// assumes source 6 (every mclk) when irq gaps are checked
`timescale 1ns/10ps
module ecdp_channel_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire ecdp_pkg::ecdp_bus_req_t bus_req,
   input wire logic [7:0] rd_data,
   // pins
   input wire logic event_input_pin,
   input wire logic low_speed_osc,
   input wire logic divider_out_pin,
   input wire logic pwm_out_pin,
   input wire logic channel_match_irq
);
   // --------------------------------
   // shadow of control, quiet time
   // --------------------------------
   logic [7:0] ctrl_r, match_r;
   logic [9:0] quiet_r;
   logic [8:0] gap_r;
   logic run, dv, pw;
   assign run = ctrl_r[3];
   assign dv = ctrl_r[1:0] == 2'h1;
   assign pw = ctrl_r[1:0] == 2'h3;
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_r <= 8'h00;
         match_r <= 8'h00;
         quiet_r <= 10'h000;
      end else begin
         if (bus_req.wr && bus_req.addr == 2'h0) ctrl_r <= bus_req.wdata;
         if (bus_req.wr && bus_req.addr == 2'h1) match_r <= bus_req.wdata;
         quiet_r <= bus_req.wr ? 10'h000 : quiet_r + {9'h000, quiet_r != 10'h3FF};
      end
      gap_r <= (rst || channel_match_irq) ? 9'h000 : gap_r + {8'h00, gap_r != 9'h1FF};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_irq_pulse;
      channel_match_irq && match_r > 8'h01 |=> !channel_match_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
   property p_pins_same;
      divider_out_pin == pwm_out_pin;
   endproperty
   a_pins_same: assert property (p_pins_same) else $error("pins differ");
   property p_rst_pins;
      disable iff (1'b0) rst |=> divider_out_pin && !channel_match_irq;
   endproperty
   a_rst_pins: assert property (p_rst_pins) else $error("reset state wrong");
   property p_stop_hold;
      !run && quiet_r >= 10'd3 |-> $stable(divider_out_pin) && !channel_match_irq;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped pin moved");
   property p_div_irq;
      run && dv && quiet_r >= 10'd3 |-> !$stable(divider_out_pin) == channel_match_irq;
   endproperty
   a_div_irq: assert property (p_div_irq) else $error("toggle without irq");
   property p_pwm_irq;
      run && pw && quiet_r >= 10'd3 && channel_match_irq |-> !$stable(pwm_out_pin);
   endproperty
   a_pwm_irq: assert property (p_pwm_irq) else $error("irq without toggle");
   property p_evt_edge;
      run && ctrl_r[1:0] == 2'h0 && quiet_r >= 10'd5 && channel_match_irq
         |-> !$past(event_input_pin, 1) && $past(event_input_pin, 2);
   endproperty
   a_evt_edge: assert property (p_evt_edge) else $error("irq not after fall");
   property p_gap;
      run && (dv || pw) && ctrl_r[6:4] == 3'h6 && quiet_r >= 10'd600 && channel_match_irq
         |-> gap_r == (pw ? 9'h0FF : {1'b0, match_r} - 9'h001);
   endproperty
   a_gap: assert property (p_gap) else $error("irq spacing wrong");
   c_evt: cover property (run && ctrl_r[1:0] == 2'h0 && channel_match_irq);
   c_div: cover property (run && dv && channel_match_irq);
   c_pwm: cover property (run && pw && channel_match_irq);
endmodule
bind ecdp_channel ecdp_channel_chk u_chk (.mclk(mclk), .rst(rst), .bus_req(bus_req),
   .rd_data(rd_data), .event_input_pin(event_input_pin), .low_speed_osc(low_speed_osc),
   .divider_out_pin(divider_out_pin), .pwm_out_pin(pwm_out_pin),
   .channel_match_irq(channel_match_irq));

// >>> ecdp_evt_src.sv
// external event source and slow oscillator
// assumes the bench raises go for whole event bursts
`timescale 1ns/10ps
module ecdp_evt_src (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // burst control
   input wire logic go,
   input wire logic [3:0] half,
   // driven lines
   output logic event_pin,
   output logic slow_osc
);
   logic [3:0] ph_r;
   logic [1:0] ls_r;
   assign slow_osc = ls_r[1];
   always_ff @(posedge mclk) begin
      ls_r <= rst ? 2'h0 : ls_r + 2'h1;
      if (rst || !go) begin
         ph_r <= 4'h1;
         event_pin <= 1'b1;
      end else if (ph_r >= half && ph_r >= 4'h2) begin
         ph_r <= 4'h1;
         event_pin <= ~event_pin;
      end else begin
         ph_r <= ph_r + 4'h1;
      end
   end
endmodule

// >>> ecdp_map.svh
// ecdp_map.svh: register offsets, field positions and reset values of one
// eight-bit counter/divider/pwm channel.
// assumes a plain 2-bit register address and 8-bit register data.
`ifndef ECDP_MAP_SVH
`define ECDP_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ECDP_OFF_CTRL 2'h0
`define ECDP_OFF_MATCH 2'h1
`define ECDP_OFF_DUTY 2'h2
`define ECDP_OFF_STAT 2'h3

// ----------------------------------------------------------------------
// channel_control_reg fields
// ----------------------------------------------------------------------
`define ECDP_CTRL_PRESET_BIT 7
`define ECDP_CTRL_RUN_BIT 3
`define ECDP_CTRL_PRESRC_BIT 2

// ----------------------------------------------------------------------
// reset values and counter limits
// ----------------------------------------------------------------------
`define ECDP_RST_CTRL 8'h00
`define ECDP_RST_MATCH 8'h00
`define ECDP_RST_DUTY 8'h00
`define ECDP_CNT_TOP 8'hFF
`define ECDP_PRE_W 11
`define ECDP_LS_W 3

`endif

// >>> ecdp_pkg.sv
// ecdp_pkg.sv: types shared by the channel and its prescaler.
// assumes ecdp_map.svh for all offsets and values.
package ecdp_pkg;

   // mode codes, gray along event -> divider -> pwm
   typedef enum logic [1:0] {
      ECDP_MODE_EVT = 2'h0,
      ECDP_MODE_DIV = 2'h1,
      ECDP_MODE_PWM = 2'h3,
      ECDP_MODE_RSV = 2'h2
   } ecdp_mode_t;

   // source clock select codes
   typedef enum logic [2:0] {
      ECDP_SRC_DIV11 = 3'h0,
      ECDP_SRC_DIV7 = 3'h1,
      ECDP_SRC_DIV5 = 3'h2,
      ECDP_SRC_DIV3 = 3'h3,
      ECDP_SRC_LS = 3'h4,
      ECDP_SRC_DIV1 = 3'h5,
      ECDP_SRC_FULL = 3'h6,
      ECDP_SRC_NONE = 3'h7
   } ecdp_src_t;

   // channel_control_reg layout
   typedef struct packed {
      logic preset;
      ecdp_src_t src;
      logic run;
      logic pre_src;
      ecdp_mode_t mode;
   } ecdp_ctrl_t;

   // register port request
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ecdp_bus_req_t;

endpackage

// >>> ecdp_prescaler.sv
// ecdp_prescaler.sv: source clock tick generator for one channel.
// assumes low_speed_osc is a level synchronous to mclk.
`timescale 1ns/10ps
`include "ecdp_map.svh"

module ecdp_prescaler (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // selection
   input wire ecdp_pkg::ecdp_src_t src,
   input wire logic pre_src,
   input wire logic low_speed_osc,
   // one-cycle source tick
   output logic tick
);

   logic [`ECDP_PRE_W-1:0] div_r, div_nxt;
   logic [`ECDP_LS_W-1:0] ls_cnt_r, ls_cnt_nxt;
   logic ls_prev_r, ls_prev_nxt;
   logic tick_r, tick_nxt;
   logic ls_tick;

   // ----------------------------------------------------------------------
   // divider chains and tap select
   // ----------------------------------------------------------------------
   always_comb begin
      ls_tick = low_speed_osc & ~ls_prev_r;
      div_nxt = div_r + `ECDP_PRE_W'h001;
      ls_prev_nxt = low_speed_osc;
      ls_cnt_nxt = ls_cnt_r;
      if (ls_tick) begin
         ls_cnt_nxt = ls_cnt_r + `ECDP_LS_W'h1;
      end
      case (src)
         ecdp_pkg::ECDP_SRC_DIV11: begin
            if (pre_src) begin
               tick_nxt = ls_tick & (&ls_cnt_r);
            end else begin
               tick_nxt = &div_r;
            end
         end
         ecdp_pkg::ECDP_SRC_DIV7: tick_nxt = &div_r[6:0];
         ecdp_pkg::ECDP_SRC_DIV5: tick_nxt = &div_r[4:0];
         ecdp_pkg::ECDP_SRC_DIV3: tick_nxt = &div_r[2:0];
         ecdp_pkg::ECDP_SRC_LS: tick_nxt = ls_tick;
         ecdp_pkg::ECDP_SRC_DIV1: tick_nxt = div_r[0];
         ecdp_pkg::ECDP_SRC_FULL: tick_nxt = 1'b1;
         default: tick_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         div_r <= '0;
         ls_cnt_r <= '0;
         ls_prev_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         ls_cnt_r <= ls_cnt_nxt;
         ls_prev_r <= ls_prev_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

endmodule

// >>> test_eight_bit_counter_divider_pwm.sv
// self-checking bench for one channel
// assumes ecdp_channel with its bound checker and the event source model
`timescale 1ns/10ps
module test_eight_bit_counter_divider_pwm;
   logic mclk, rst, go, evt, lso, div_pin, pwm_pin, irq, p;
   ecdp_pkg::ecdp_bus_req_t req;
   logic [7:0] rd_data;
   logic [8:0] cnt;
   int n_errors, num_checks, n_irq;
   ecdp_channel DUT (.mclk(mclk), .rst(rst), .bus_req(req), .rd_data(rd_data),
      .event_input_pin(evt), .low_speed_osc(lso), .divider_out_pin(div_pin),
      .pwm_out_pin(pwm_pin), .channel_match_irq(irq));
   ecdp_evt_src u_src (.mclk(mclk), .rst(rst), .go(go), .half(4'h2), .event_pin(evt),
      .slow_osc(lso));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) if (irq === 1'b1) n_irq++;
   // ----------------
   // access tasks
   // ----------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h", $time, m, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string m);
      @(posedge mclk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 chk(rd_data, exp, m);
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 300 && irq !== 1'b1; i++) cyc(1);
      chk({7'h0, irq}, 8'h01, "irq missing");
   endtask
   task automatic irq_over(input int n, input logic [7:0] exp, input string m);
      @(negedge mclk) n_irq = 0;
      cyc(n);
      chk(n_irq[7:0], exp, m);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #60000;
      n_errors++;
      print_verdict();
   end
   // ----------------
   // tests
   // ----------------
   initial begin
      rst = 1'b1;
      go = 1'b0;
      req = '0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd(2'h0, 8'h00, "ctrl reset");
      rd(2'h2, 8'h00, "duty reset");
      chk({7'h0, div_pin}, 8'h01, "pin reset");
      wr(2'h3, 8'h55);
      rd(2'h3, 8'h00, "count write");
      $display("reset test done");
      wr(2'h1, 8'h03);
      wr(2'h0, 8'h08);
      @(negedge mclk) n_irq = 0;
      @(posedge mclk) go <= 1'b1;
      cyc(23);
      @(posedge mclk) go <= 1'b0;
      cyc(6);
      chk(n_irq[7:0], 8'h02, "event irqs");
      $display("event test done");
      wr(2'h0, 8'h00);
      wr(2'h1, 8'h02);
      wr(2'h0, 8'h69);
      cyc(650);
      irq_over(100, 8'h32, "divider irqs");
      wr(2'h0, 8'h61);
      cyc(3);
      p = div_pin;
      cyc(20);
      chk({7'h0, div_pin}, {7'h0, p}, "stop hold");
      wr(2'h0, 8'hE1);
      cyc(2);
      chk({7'h0, div_pin}, 8'h00, "preset one");
      wr(2'h0, 8'h61);
      cyc(2);
      chk({7'h0, div_pin}, 8'h01, "preset zero");
      // slow oscillator source: a tick every four mclk, an irq every eight
      wr(2'h0, 8'h49);
      cyc(20);
      irq_over(80, 8'h0A, "slow source irqs");
      wr(2'h0, 8'h41);
      $display("divider test done");
      wr(2'h2, 8'h80);
      rd(2'h2, 8'h80, "duty stopped");
      wr(2'h0, 8'h6B);
      cyc(700);
      wait_irq();
      wr(2'h2, 8'h40);
      rd(2'h2, 8'h80, "duty before irq");
      wait_irq();
      rd(2'h2, 8'h40, "duty after irq");
      wait_irq();
      cnt = 9'h000;
      repeat (256) begin
         cyc(1);
         if (pwm_pin === 1'b0) cnt++;
      end
      chk(cnt[7:0], 8'hC0, "pwm low ticks");
      irq_over(512, 8'h02, "pwm irqs");
      wr(2'h0, 8'h63);
      cyc(3);
      p = pwm_pin;
      cyc(20);
      chk({7'h0, pwm_pin}, {7'h0, p}, "pwm stop hold");
      wr(2'h0, 8'hE3);
      cyc(2);
      chk({7'h0, pwm_pin}, 8'h00, "pwm preset one");
      @(posedge mclk) rst <= 1'b1;
      cyc(8);
      @(posedge mclk) rst <= 1'b0;
      cyc(2);
      chk({7'h0, pwm_pin}, 8'h01, "pwm pin reset");
      rd(2'h0, 8'h00, "ctrl after reset");
      $display("pwm test done");
      print_verdict();
   end
endmodule
